// File: mcw_consts.vh
// Constants for the machine control word and its fault gate
// Behaviour
// - Line-fill inhibit set stops new fills; hits, write updates, invalidations continue.
// - Write-back mode writes bus only on miss, modified evict, locked, flush evict.
// - Write-through mode sends every write, hits included, to the external bus.
// - Writes cannot change the write-policy bit while write-policy lock is set.
// - Alignment faults need align mask set; mask clear blocks all alignment faults.
// - Write guard clear lets levels 0-2 write read-only pages; set faults all levels.
// - Numeric errors go to vector 16 when routing set, else external interrupt signalling.
// - Bit 4 is reserved, always reads one and ignores writes.
// - Hardware sets the task-switched flag on every task switch.
// - Task-switched flag set makes any escape instruction fault.
// - Emulate bit set makes every escape instruction raise fault 7.
// - Wait faults only when monitor and task-switched are both one.
// - Monitor bit never affects escape instruction execution.
// - Escape instructions execute only with task-switched and emulate both zero.
// - Protection enable selects protected mode; clear means real mode addressing.
`ifndef MCW_CONSTS_VH
`define MCW_CONSTS_VH
`define MCW_BIT_FILL_INHIBIT 30
`define MCW_BIT_WRITEBACK 29
`define MCW_BIT_ALIGN_MASK 18
`define MCW_BIT_WRITE_GUARD 16
`define MCW_BIT_NUM_ROUTE 5
`define MCW_BIT_RSVD_ONE 4
`define MCW_BIT_TASK_SW 3
`define MCW_BIT_EMULATE 2
`define MCW_BIT_MONITOR 1
`define MCW_BIT_PROTECT 0
`define MCW_DEFINED_MASK 32'h6005_003F
`define MCW_FORCED_ONES 32'h0000_0010
`define MCW_RESET 32'h0000_0010
`define CC2_BIT_WP_LOCK 2
`define CC2_MASK 32'h0000_0004
`define CC2_RESET 32'h0000_0000
`define OFS_MCW 4'h0
`define OFS_CC2 4'h4
`define OFS_STATUS 4'h8
`define OFS_MASK 4'hC
`define EVT_WIDTH 6
`define EVT_DNA 0
`define EVT_ALIGN 1
`define EVT_PROT 2
`define EVT_TASK_SW 3
`define EVT_NUM_VEC 4
`define EVT_NUM_EXT 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: machine_control_word_fault_gate.v
// Machine control word, cache policy, fault gating and its AXI4-Lite register slave
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mcw_consts.vh"
module machine_control_word_fault_gate (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // AXI4-Lite write address
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [3:0] s_axi_awaddr,
   // AXI4-Lite write data
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [3:0] s_axi_araddr,
   // AXI4-Lite read data
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   // Instruction stream access to the control word
   input wire mcwWrEn,
   input wire [31:0] mcwWrData,
   input wire taskSwitch,
   output reg [31:0] mcwValue,
   // Floating point gate
   input wire fpuInstrValid,
   input wire waitInstr,
   output reg deviceUnavailableFault,
   output reg fpuInstrAccept,
   // Alignment check
   input wire accessValid,
   input wire misaligned,
   input wire alignCheckFlag,
   output reg alignFault,
   // Page write protection
   input wire pageWriteValid,
   input wire readOnlyPage,
   input wire [1:0] privLevel,
   output reg writeProtFault,
   // Numeric error routing
   input wire fpuError,
   output reg numVector16,
   output reg numExtIrq,
   // Cache policy
   input wire cacheMiss,
   input wire cacheWrite,
   input wire cacheHit,
   input wire lockedOp,
   input wire modifiedEvict,
   input wire flushEvict,
   input wire inquiryInval,
   output reg lineFillStart,
   output reg cacheLineUpdate,
   output reg busWrite,
   output reg lineInvalidate,
   // Mode and interrupt
   output reg protectedMode,
   output reg irq
);

   // Byte lane merge of a bus write
   function [31:0] laneMerge;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0] strb;
      integer i;
      begin
         laneMerge = oldVal;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               laneMerge[i*8 +: 8] = newVal[i*8 +: 8];
            end
         end
      end
   endfunction

   // Legal control word value after a write of any source
   function [31:0] mcwFilter;
      input [31:0] oldVal;
      input [31:0] newVal;
      input lock;
      begin
         mcwFilter = (newVal & `MCW_DEFINED_MASK) | `MCW_FORCED_ONES;
         if (lock) begin
            mcwFilter[`MCW_BIT_WRITEBACK] = oldVal[`MCW_BIT_WRITEBACK];
         end
      end
   endfunction

   function addrMapped;
      input [3:0] a;
      begin
         addrMapped = (a == `OFS_MCW) || (a == `OFS_CC2) ||
            (a == `OFS_STATUS) || (a == `OFS_MASK);
      end
   endfunction

   reg [31:0] mcw_q;
   reg [31:0] mcw_d;
   reg [31:0] cc2_q;
   reg [31:0] cc2_d;
   reg [`EVT_WIDTH-1:0] status_q;
   reg [`EVT_WIDTH-1:0] status_d;
   reg [`EVT_WIDTH-1:0] mask_q;
   reg [`EVT_WIDTH-1:0] mask_d;
   reg [3:0] awAddr_q;
   reg awHave_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg wHave_q;
   reg [`EVT_WIDTH-1:0] events;
   reg [31:0] readWord;
   reg dnaNow;
   reg alignNow;
   reg protNow;
   wire awFire;
   wire wFire;
   wire arFire;
   wire doWrite;
   wire lockNw;
   wire tsBit;
   wire emBit;
   wire mpBit;

   assign awFire = s_axi_awvalid && s_axi_awready;
   assign wFire = s_axi_wvalid && s_axi_wready;
   assign arFire = s_axi_arvalid && s_axi_arready;
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   assign lockNw = cc2_q[`CC2_BIT_WP_LOCK];
   assign tsBit = mcw_q[`MCW_BIT_TASK_SW];
   assign emBit = mcw_q[`MCW_BIT_EMULATE];
   assign mpBit = mcw_q[`MCW_BIT_MONITOR];

   // Floating point, alignment and protection decisions
   always @* begin
      dnaNow = 1'b0;
      if (fpuInstrValid) begin
         if (waitInstr) begin
            dnaNow = mpBit && tsBit;
         end else begin
            // Escape path never looks at the monitor bit
            dnaNow = tsBit || emBit;
         end
      end
      alignNow = accessValid && misaligned && alignCheckFlag &&
         mcw_q[`MCW_BIT_ALIGN_MASK];
      // Level 3 always faults on read-only pages; guard extends it to 0-2
      protNow = pageWriteValid && readOnlyPage &&
         ((privLevel == 2'h3) || mcw_q[`MCW_BIT_WRITE_GUARD]);
   end

   always @* begin
      events = {`EVT_WIDTH{1'b0}};
      events[`EVT_DNA] = dnaNow;
      events[`EVT_ALIGN] = alignNow;
      events[`EVT_PROT] = protNow;
      events[`EVT_TASK_SW] = taskSwitch;
      events[`EVT_NUM_VEC] = fpuError && mcw_q[`MCW_BIT_NUM_ROUTE];
      events[`EVT_NUM_EXT] = fpuError && !mcw_q[`MCW_BIT_NUM_ROUTE];
   end

   // Next register state; hardware sets win over software clears
   always @* begin
      mcw_d = mcw_q;
      cc2_d = cc2_q;
      mask_d = mask_q;
      status_d = status_q;
      if (doWrite) begin
         case (awAddr_q)
            `OFS_MCW: begin
               mcw_d = mcwFilter(mcw_q, laneMerge(mcw_q, wData_q, wStrb_q), lockNw);
            end
            `OFS_CC2: begin
               cc2_d = laneMerge(cc2_q, wData_q, wStrb_q) & `CC2_MASK;
            end
            `OFS_STATUS: begin
               if (wStrb_q[0]) begin
                  status_d = status_q & ~wData_q[`EVT_WIDTH-1:0];
               end
            end
            `OFS_MASK: begin
               if (wStrb_q[0]) begin
                  mask_d = wData_q[`EVT_WIDTH-1:0];
               end
            end
            default: begin
               mcw_d = mcw_q;
            end
         endcase
      end
      // Instruction stream write takes precedence over a bus write
      if (mcwWrEn) begin
         mcw_d = mcwFilter(mcw_q, mcwWrData, lockNw);
      end
      if (taskSwitch) begin
         mcw_d[`MCW_BIT_TASK_SW] = 1'b1;
      end
      status_d = status_d | events;
   end

   always @* begin
      case (s_axi_araddr)
         `OFS_MCW: begin
            readWord = mcw_q;
         end
         `OFS_CC2: begin
            readWord = cc2_q;
         end
         `OFS_STATUS: begin
            readWord = {{(32-`EVT_WIDTH){1'b0}}, status_q};
         end
         `OFS_MASK: begin
            readWord = {{(32-`EVT_WIDTH){1'b0}}, mask_q};
         end
         default: begin
            readWord = 32'h0000_0000;
         end
      endcase
   end

   // Register state
   always @(posedge core_clk) begin
      if (srst) begin
         mcw_q <= `MCW_RESET;
         cc2_q <= `CC2_RESET;
         status_q <= {`EVT_WIDTH{1'b0}};
         mask_q <= {`EVT_WIDTH{1'b0}};
      end else begin
         mcw_q <= mcw_d;
         cc2_q <= cc2_d;
         status_q <= status_d;
         mask_q <= mask_d;
      end
   end

   // AXI4-Lite write channels, address and data accepted in either order
   always @(posedge core_clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 4'h0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !awHave_q && !s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid && !s_axi_wready && !wHave_q && !s_axi_bvalid;
         if (awFire) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (wFire) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addrMapped(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channels
   always @(posedge core_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (arFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= addrMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Core-facing outputs, one cycle after their cause
   always @(posedge core_clk) begin
      if (srst) begin
         mcwValue <= `MCW_RESET;
         deviceUnavailableFault <= 1'b0;
         fpuInstrAccept <= 1'b0;
         alignFault <= 1'b0;
         writeProtFault <= 1'b0;
         numVector16 <= 1'b0;
         numExtIrq <= 1'b0;
         lineFillStart <= 1'b0;
         cacheLineUpdate <= 1'b0;
         busWrite <= 1'b0;
         lineInvalidate <= 1'b0;
         protectedMode <= 1'b0;
         irq <= 1'b0;
      end else begin
         mcwValue <= mcw_d;
         deviceUnavailableFault <= dnaNow;
         fpuInstrAccept <= fpuInstrValid && !dnaNow;
         alignFault <= alignNow;
         writeProtFault <= protNow;
         numVector16 <= events[`EVT_NUM_VEC];
         numExtIrq <= events[`EVT_NUM_EXT];
         // Inhibit only blocks new fills; hits and snoops carry on
         lineFillStart <= cacheMiss && !mcw_q[`MCW_BIT_FILL_INHIBIT];
         cacheLineUpdate <= cacheWrite && cacheHit;
         lineInvalidate <= inquiryInval;
         if (mcw_q[`MCW_BIT_WRITEBACK]) begin
            busWrite <= (cacheWrite && (!cacheHit || lockedOp)) ||
               modifiedEvict || flushEvict;
         end else begin
            busWrite <= cacheWrite;
         end
         protectedMode <= mcw_d[`MCW_BIT_PROTECT];
         irq <= |(status_d & mask_d);
      end
   end

endmodule
`default_nettype wire

// File: mcw_gate_asserts.sv
// Port assertions for the control word fault gate
`timescale 1ns/1ps
`default_nettype none
`include "mcw_consts.vh"
module mcw_gate_asserts (
   // Clock, reset and control word
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [31:0] mcwValue,
   // Floating point gate
   input wire logic fpuInstrValid,
   input wire logic waitInstr,
   input wire logic deviceUnavailableFault,
   input wire logic fpuInstrAccept,
   // Alignment and numeric errors
   input wire logic accessValid,
   input wire logic misaligned,
   input wire logic alignCheckFlag,
   input wire logic alignFault,
   input wire logic fpuError,
   input wire logic numVector16,
   input wire logic numExtIrq,
   // Cache policy
   input wire logic cacheMiss,
   input wire logic cacheWrite,
   input wire logic cacheHit,
   input wire logic lineFillStart,
   input wire logic busWrite
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_escFault;
      fpuInstrValid && !waitInstr && (mcwValue[3] || mcwValue[2]) |=> deviceUnavailableFault && !fpuInstrAccept;
   endproperty
   a_escFault: assert property (p_escFault) else $error("escape not faulted");
   property p_escRun;
      fpuInstrValid && !waitInstr && !mcwValue[3] && !mcwValue[2] |=> fpuInstrAccept && !deviceUnavailableFault;
   endproperty
   a_escRun: assert property (p_escRun) else $error("escape faulted");
   property p_wait;
      fpuInstrValid && waitInstr |=> deviceUnavailableFault == ($past(mcwValue[3]) && $past(mcwValue[1]));
   endproperty
   a_wait: assert property (p_wait) else $error("wait gate wrong");
   property p_rsvd;
      mcwValue[4] && (mcwValue & ~`MCW_DEFINED_MASK) == 32'h0000_0000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
   property p_align;
      accessValid && misaligned && alignCheckFlag |=> alignFault == $past(mcwValue[18]);
   endproperty
   a_align: assert property (p_align) else $error("align fault wrong");
   property p_route;
      fpuError |=> numVector16 == $past(mcwValue[5]) && numExtIrq == !$past(mcwValue[5]);
   endproperty
   a_route: assert property (p_route) else $error("numeric route wrong");
   property p_fill;
      cacheMiss && mcwValue[30] |=> !lineFillStart;
   endproperty
   a_fill: assert property (p_fill) else $error("fill while inhibited");
   property p_thru;
      cacheWrite && cacheHit && !mcwValue[29] |=> busWrite;
   endproperty
   a_thru: assert property (p_thru) else $error("write hit not on bus");
   c_fault: cover property (fpuInstrValid ##1 deviceUnavailableFault);
   c_align: cover property (accessValid ##1 alignFault);
   c_thru: cover property (cacheWrite && cacheHit ##1 busWrite);
endmodule
`default_nettype wire

// File: test_machine_control_word_fault_gate.sv
// Self-checking bench for the control word fault gate
`timescale 1ns/1ps
`default_nettype none
`include "mcw_consts.vh"
module test_machine_control_word_fault_gate;
   logic core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, mcwWrData, mcwValue, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, privLevel, rsp;
   logic mcwWrEn, taskSwitch, fpuInstrValid, waitInstr, deviceUnavailableFault, fpuInstrAccept;
   logic accessValid, misaligned, alignCheckFlag, alignFault, pageWriteValid, readOnlyPage, writeProtFault;
   logic fpuError, numVector16, numExtIrq, cacheMiss, cacheWrite, cacheHit, lockedOp, modifiedEvict;
   logic flushEvict, inquiryInval, lineFillStart, cacheLineUpdate, busWrite, lineInvalidate, protectedMode, irq;
   int err_total, checks_done;
   machine_control_word_fault_gate i_dut (
      .core_clk(core_clk), .srst(srst),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .mcwWrEn(mcwWrEn), .mcwWrData(mcwWrData), .taskSwitch(taskSwitch), .mcwValue(mcwValue),
      .fpuInstrValid(fpuInstrValid), .waitInstr(waitInstr), .deviceUnavailableFault(deviceUnavailableFault),
      .fpuInstrAccept(fpuInstrAccept), .accessValid(accessValid), .misaligned(misaligned),
      .alignCheckFlag(alignCheckFlag), .alignFault(alignFault), .pageWriteValid(pageWriteValid),
      .readOnlyPage(readOnlyPage), .privLevel(privLevel), .writeProtFault(writeProtFault),
      .fpuError(fpuError), .numVector16(numVector16), .numExtIrq(numExtIrq), .cacheMiss(cacheMiss),
      .cacheWrite(cacheWrite), .cacheHit(cacheHit), .lockedOp(lockedOp), .modifiedEvict(modifiedEvict),
      .flushEvict(flushEvict), .inquiryInval(inquiryInval), .lineFillStart(lineFillStart),
      .cacheLineUpdate(cacheLineUpdate), .busWrite(busWrite), .lineInvalidate(lineInvalidate),
      .protectedMode(protectedMode), .irq(irq));
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      // Each channel dropped at its own handshake edge
      while (!(aw && w)) begin
         @(posedge core_clk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      do @(posedge core_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // Control word by instruction stream, one cycle of stimulus, outputs one cycle later
   task core(input logic [31:0] m, input logic [12:0] s, input logic [9:0] e);
      @(posedge core_clk);
      mcwWrEn <= 1;
      mcwWrData <= m;
      @(posedge core_clk);
      mcwWrEn <= 0;
      {fpuInstrValid, waitInstr, accessValid, misaligned, alignCheckFlag, pageWriteValid, readOnlyPage, fpuError,
         cacheMiss, cacheWrite, cacheHit, lockedOp, inquiryInval} <= s;
      @(posedge core_clk);
      {fpuInstrValid, waitInstr, accessValid, misaligned, alignCheckFlag, pageWriteValid, readOnlyPage, fpuError,
         cacheMiss, cacheWrite, cacheHit, lockedOp, inquiryInval} <= 13'h0000;
      @(negedge core_clk);
      chk({22'h0, deviceUnavailableFault, fpuInstrAccept, alignFault, writeProtFault, numVector16, numExtIrq,
         lineFillStart, cacheLineUpdate, busWrite, lineInvalidate}, {22'h0, e});
   endtask
   task tRegs;
      axiRd(`OFS_MCW, rd, rsp);
      chk(rd, `MCW_RESET);
      chk({30'h0, rsp}, {30'h0, `RESP_OKAY});
      axiWr(`OFS_MCW, 32'hFFFF_FFFF, rsp);
      chk({30'h0, rsp}, {30'h0, `RESP_OKAY});
      axiRd(`OFS_MCW, rd, rsp);
      chk(rd, `MCW_DEFINED_MASK);
      chk({31'h0, protectedMode}, 32'h1);
      axiWr(`OFS_MCW, 32'h0, rsp);
      chk({31'h0, protectedMode}, 32'h0);
      chk(mcwValue, `MCW_FORCED_ONES);
      axiWr(4'h2, 32'h0, rsp);
      chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
      axiRd(4'h2, rd, rsp);
      chk(rd, 32'h0000_0000);
      chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
      $display("registers test done");
   endtask
   task tLock;
      axiWr(`OFS_CC2, `CC2_MASK, rsp);
      axiWr(`OFS_MCW, 32'h2000_0000, rsp);
      chk(mcwValue, `MCW_RESET);
      axiWr(`OFS_CC2, 32'h0, rsp);
      axiWr(`OFS_MCW, 32'h2000_0000, rsp);
      chk(mcwValue, 32'h2000_0010);
      $display("policy lock test done");
   endtask
   task tCore;
      logic f;
      for (int i = 0; i < 16; i++) begin
         f = i[3] ? (i[2] & i[0]) : (i[2] | i[1]);
         core({28'h1, i[2:0], 1'b0}, {1'b1, i[3], 11'h0}, {f, !f, 8'h0});
      end
      core(32'h0004_0010, 13'h0700, 10'h080);
      core(32'h0000_0010, 13'h0700, 10'h000);
      core(32'h0000_0010, 13'h00C0, 10'h000);
      core(32'h0001_0010, 13'h00C0, 10'h040);
      // User level faults on read-only pages even with the guard clear
      @(posedge core_clk);
      privLevel <= 2'h3;
      core(32'h0000_0010, 13'h00C0, 10'h040);
      core(32'h0000_0030, 13'h0020, 10'h020);
      core(32'h0000_0010, 13'h0020, 10'h010);
      core(32'h0000_0010, 13'h0010, 10'h008);
      core(32'h4000_0010, 13'h0010, 10'h000);
      core(32'h4000_0010, 13'h0001, 10'h001);
      core(32'h4000_0010, 13'h000C, 10'h006);
      core(32'h2000_0010, 13'h000C, 10'h004);
      core(32'h2000_0010, 13'h000E, 10'h006);
      core(32'h2000_0010, 13'h0008, 10'h002);
      // Evictions reach the bus in write-back mode
      @(posedge core_clk);
      privLevel <= 2'h0;
      modifiedEvict <= 1;
      @(posedge core_clk);
      modifiedEvict <= 0;
      flushEvict <= 1;
      @(negedge core_clk);
      chk({31'h0, busWrite}, 32'h1);
      @(posedge core_clk);
      flushEvict <= 0;
      @(negedge core_clk);
      chk({31'h0, busWrite}, 32'h1);
      @(posedge core_clk);
      @(negedge core_clk);
      chk({31'h0, busWrite}, 32'h0);
      $display("core gate test done");
   endtask
   task tIrq;
      axiWr(`OFS_STATUS, 32'h3F, rsp);
      @(posedge core_clk);
      taskSwitch <= 1;
      @(posedge core_clk);
      taskSwitch <= 0;
      axiRd(`OFS_STATUS, rd, rsp);
      chk(rd, 32'h8);
      chk(mcwValue & 32'h8, 32'h8);
      chk({31'h0, irq}, 32'h0);
      axiWr(`OFS_MASK, 32'h8, rsp);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      axiWr(`OFS_STATUS, 32'h8, rsp);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      axiWr(`OFS_MASK, 32'h0, rsp);
      $display("interrupt test done");
   endtask
   initial begin
      err_total = 0;
      checks_done = 0;
      srst = 1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr,
         s_axi_wdata, mcwWrData, privLevel, mcwWrEn, taskSwitch, fpuInstrValid, waitInstr, accessValid,
         misaligned, alignCheckFlag, pageWriteValid, readOnlyPage, fpuError, cacheMiss, cacheWrite, cacheHit,
         lockedOp, modifiedEvict, flushEvict, inquiryInval} = '0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge core_clk);
      srst <= 0;
      tRegs();
      tLock();
      tCore();
      tIrq();
      results();
   end
   initial begin
      repeat (6000) @(posedge core_clk);
      err_total++;
      results();
   end
endmodule
bind machine_control_word_fault_gate mcw_gate_asserts i_chk (.core_clk(core_clk), .srst(srst),
   .mcwValue(mcwValue), .fpuInstrValid(fpuInstrValid), .waitInstr(waitInstr), .fpuInstrAccept(fpuInstrAccept),
   .deviceUnavailableFault(deviceUnavailableFault), .accessValid(accessValid), .misaligned(misaligned),
   .alignCheckFlag(alignCheckFlag), .alignFault(alignFault), .fpuError(fpuError), .numVector16(numVector16),
   .numExtIrq(numExtIrq), .cacheMiss(cacheMiss), .cacheWrite(cacheWrite), .cacheHit(cacheHit),
   .lineFillStart(lineFillStart), .busWrite(busWrite));
`default_nettype wire
